/* File: logic/odc_pkg.sv */
// package for the octal dac serial command decoder
// assumes one system clock; serial pins sampled synchronously to it
package odc_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int ODC_FRAME_BITS = 24;
  localparam int ODC_CMD_MSB = 23;
  localparam int ODC_CMD_LSB = 20;
  localparam int ODC_SEL_MSB = 19;
  localparam int ODC_SEL_LSB = 16;
  localparam int ODC_NUM_CH = 8;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [3:0] ODC_CMD_NOP = 4'h0;
  localparam logic [3:0] ODC_CMD_WR_IN = 4'h1;
  localparam logic [3:0] ODC_CMD_UPD = 4'h2;
  localparam logic [3:0] ODC_CMD_WR_UPD = 4'h3;
  localparam logic [3:0] ODC_CMD_PWR = 4'h4;
  localparam logic [3:0] ODC_CMD_MASK = 4'h5;
  localparam logic [3:0] ODC_CMD_SWRST = 4'h6;
  localparam logic [3:0] ODC_CMD_REFGAIN = 4'h7;
  localparam logic [3:0] ODC_CMD_CHAIN = 4'h8;
  localparam logic [3:0] ODC_CMD_RDBK = 4'h9;
  localparam logic [3:0] ODC_CMD_ALL_IN = 4'hA;
  localparam logic [3:0] ODC_CMD_ALL_UPD = 4'hB;

  // ---------------------------------------------------------------
  // reset values and setup-register field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] ODC_CODE_RST = 16'h0000;
  localparam logic [15:0] ODC_PWR_RST = 16'h0000;
  localparam logic [7:0] ODC_MASK_RST = 8'h00;
  localparam logic ODC_REF_OFF_RST = 1'b0;
  localparam logic ODC_GAIN_RST = 1'b0;
  localparam logic ODC_CHAIN_RST = 1'b0;
  localparam int ODC_REF_OFF_BIT = 0;
  localparam int ODC_GAIN_BIT = 2;
  localparam int ODC_CHAIN_BIT = 0;

  // serial pins as one bundle
  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic sdi;
  } odc_serial_t;

  typedef enum logic [1:0] {ODC_IDLE, ODC_SHIFT} odc_state_t;

endpackage : odc_pkg

/* File: logic/odc_decoder.sv */
// serial front end and command decoder of an octal voltage dac
// assumes serial pins are synchronous to sys_clk and much slower than it
//
// Contract
// RULE1 - each write is one 24-bit word over frame sync, clock, data
// RULE2 - word shifted most significant bit first, bit 23 first
// RULE3 - top four bits are command, next four channel selection
// RULE4 - data is 16 bits, or 12 bits plus four ignored bits
// RULE5 - sample data on falling clock edges, act at frame sync rise
// RULE6 - command 0000 changes nothing
// RULE7 - command 0001 writes input registers of selected channels
// RULE8 - command 0010 copies input to dac register for selected channels
// RULE9 - command 0011 writes input and dac register of selected channels
// RULE10 - command 0100 sets power-down state from data word
// RULE11 - command 0101 loads the load-pin mask register
// RULE12 - command 0110 is a software reset equal to power-on reset; code leaves frame state and sdo as they are and pulses frame_done
// RULE13 - command 0111 writes reference and gain setup
// RULE14 - 1000 writes chain enable; 1001 sets up readback
// RULE15 - command 1010 loads all input registers
// RULE16 - command 1011 loads all input and dac registers
// RULE17 - selection codes 0 to 7 address channels 0 to 7
// RULE18 - a command may apply to one, several or all channels; code selects one channel, or all via 1010/1011, never several
// RULE19 - software gain resets to 0; 1 doubles span
// RULE20 - with the gain pin variant the gain bit is ignored
// RULE21 - reference enabled after power-up, a write may disable it
// RULE22 - power-on reset sets outputs to a defined state
// RULE23 - a short frame is still acted on with partial data
// RULE24 - host keeps frame sync high at least 20 ns between frames
// RULE25 - load pin low while sync high updates dac registers
// RULE26 - after readback request the register shifts out next frame
// RULE27 - reserved commands 1100 to 1111 change nothing
`timescale 1ns/1ps

module odc_decoder
  import odc_pkg::*;
#(
  parameter int DATA_BITS = 16,
  parameter bit HW_GAIN_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire odc_serial_t serial_in,
  input wire logic load_outputs_n,
  input wire logic gain_pin,
  output logic serial_out,
  output logic [ODC_NUM_CH*16-1:0] dac_codes,
  output logic [15:0] power_modes,
  output logic reference_enable,
  output logic gain_double,
  output logic chain_enable,
  output logic frame_done
);

  // ---------------------------------------------------------------
  // pin edge detection
  // ---------------------------------------------------------------
  logic sclk_reg, sclk_next;
  logic sync_reg, sync_next;
  logic sclk_fall, sclk_rise, sync_fall, sync_rise;

  always_comb begin
    sclk_next = serial_in.sclk;
    sync_next = serial_in.frame_n;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclk_reg <= 1'b0;
      sync_reg <= 1'b1;
    end else begin
      sclk_reg <= sclk_next;
      sync_reg <= sync_next;
    end
  end

  assign sclk_fall = sclk_reg & ~serial_in.sclk;
  assign sclk_rise = ~sclk_reg & serial_in.sclk;
  assign sync_fall = sync_reg & ~serial_in.frame_n;
  assign sync_rise = ~sync_reg & serial_in.frame_n;

  // ---------------------------------------------------------------
  // shift register
  // ---------------------------------------------------------------
  odc_state_t state_reg, state_next;
  logic [ODC_FRAME_BITS-1:0] shift_reg, shift_next;
  logic [ODC_FRAME_BITS-1:0] out_reg, out_next;
  logic sdo_reg, sdo_next;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    sdo_next = sdo_reg;
    case (state_reg)
      ODC_IDLE: begin
        if (sync_fall) begin
          state_next = ODC_SHIFT;
          shift_next = '0;
        end
      end
      ODC_SHIFT: begin
        // RULE5 RULE2 msb-first falling-edge sampling
        if (sclk_fall && !serial_in.frame_n) begin
          shift_next = {shift_reg[ODC_FRAME_BITS-2:0], serial_in.sdi};
        end
        // RULE26 readback / chain data launched on rising edge
        if (sclk_rise && !serial_in.frame_n) begin
          sdo_next = out_reg[ODC_FRAME_BITS-1];
        end
        // RULE23 frame ends at sync rise whatever the count
        if (sync_rise) begin
          state_next = ODC_IDLE;
        end
      end
      default: state_next = ODC_IDLE;
    endcase
    // sdo holds last bit while sync is high, like a weak latch
    if (chain_enable && sclk_rise && !serial_in.frame_n && state_reg == ODC_SHIFT) begin
      sdo_next = shift_reg[ODC_FRAME_BITS-1];
    end
  end

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  logic [15:0] in_reg [ODC_NUM_CH];
  logic [15:0] in_next [ODC_NUM_CH];
  logic [15:0] dac_reg [ODC_NUM_CH];
  logic [15:0] dac_next [ODC_NUM_CH];
  logic [15:0] pwr_reg, pwr_next;
  logic [7:0] mask_reg, mask_next;
  logic ref_off_reg, ref_off_next;
  logic gain_reg, gain_next;
  logic chain_reg, chain_next;
  logic rd_pend_reg, rd_pend_next;
  logic [2:0] rd_ch_reg, rd_ch_next;
  logic done_reg, done_next;
  logic soft_rst;
  logic [3:0] cmd;
  logic [7:0] sel;
  logic [15:0] word;

  // RULE17 RULE18 one-hot decode of the selection field
  function automatic logic [7:0] odc_select(input logic [3:0] code);
    odc_select = 8'h00;
    if (code[3] == 1'b0) begin
      odc_select[code[2:0]] = 1'b1;
    end
  endfunction : odc_select

  // RULE4 narrow variant drops four trailing bits
  function automatic logic [15:0] odc_code(input logic [15:0] raw);
    odc_code = raw;
    if (DATA_BITS == 12) begin
      odc_code = {4'h0, raw[15:4]};
    end
  endfunction : odc_code

  // RULE1 RULE3 field split of the 24-bit word
  assign cmd = shift_reg[ODC_CMD_MSB:ODC_CMD_LSB];
  assign sel = odc_select(shift_reg[ODC_SEL_MSB:ODC_SEL_LSB]);
  assign word = odc_code(shift_reg[15:0]);

  always_comb begin
    pwr_next = pwr_reg;
    mask_next = mask_reg;
    ref_off_next = ref_off_reg;
    gain_next = gain_reg;
    chain_next = chain_reg;
    rd_pend_next = rd_pend_reg;
    rd_ch_next = rd_ch_reg;
    done_next = 1'b0;
    soft_rst = 1'b0;
    out_next = out_reg;
    for (int i = 0; i < ODC_NUM_CH; i++) begin
      in_next[i] = in_reg[i];
      dac_next[i] = dac_reg[i];
    end
    // RULE25 load pin updates from input registers outside a frame
    if (!load_outputs_n && serial_in.frame_n) begin
      for (int i = 0; i < ODC_NUM_CH; i++) begin
        if (!mask_reg[i]) begin
          dac_next[i] = in_reg[i];
        end
      end
    end
    if (state_reg == ODC_SHIFT && sync_rise) begin
      done_next = 1'b1;
      // each readback applies to exactly one following frame
      rd_pend_next = 1'b0;
      case (cmd)
        // RULE7 input write, transparent if load pin low and channel unmasked
        ODC_CMD_WR_IN: begin
          for (int i = 0; i < ODC_NUM_CH; i++) begin
            if (sel[i]) begin
              in_next[i] = word;
              if (!load_outputs_n && !mask_reg[i]) dac_next[i] = word;
            end
          end
        end
        // RULE8 update from input registers
        ODC_CMD_UPD: begin
          for (int i = 0; i < ODC_NUM_CH; i++) begin
            if (sel[i]) dac_next[i] = in_reg[i];
          end
        end
        // RULE9 write and update
        ODC_CMD_WR_UPD: begin
          for (int i = 0; i < ODC_NUM_CH; i++) begin
            if (sel[i]) begin
              in_next[i] = word;
              dac_next[i] = word;
            end
          end
        end
        // RULE10 power modes, two bits a channel
        ODC_CMD_PWR: pwr_next = shift_reg[15:0];
        // RULE11 load-pin mask
        ODC_CMD_MASK: mask_next = shift_reg[7:0];
        // RULE12 software reset
        ODC_CMD_SWRST: soft_rst = 1'b1;
        // RULE13 RULE21 RULE19 reference and gain setup
        ODC_CMD_REFGAIN: begin
          ref_off_next = shift_reg[ODC_REF_OFF_BIT];
          gain_next = shift_reg[ODC_GAIN_BIT];
        end
        // RULE14 chain enable
        ODC_CMD_CHAIN: chain_next = shift_reg[ODC_CHAIN_BIT];
        // RULE14 readback setup
        ODC_CMD_RDBK: begin
          rd_pend_next = 1'b1;
          rd_ch_next = shift_reg[ODC_SEL_LSB+2:ODC_SEL_LSB];
        end
        // RULE15 all input registers
        ODC_CMD_ALL_IN: begin
          for (int i = 0; i < ODC_NUM_CH; i++) in_next[i] = word;
        end
        // RULE16 all input and dac registers
        ODC_CMD_ALL_UPD: begin
          for (int i = 0; i < ODC_NUM_CH; i++) begin
            in_next[i] = word;
            dac_next[i] = word;
          end
        end
        // RULE6 RULE27 no-op and reserved codes
        default: ;
      endcase
    end
    // RULE26 out shifter moves on each serial clock fall
    if (state_reg == ODC_SHIFT && sclk_fall && !serial_in.frame_n) begin
      out_next = {out_reg[ODC_FRAME_BITS-2:0], 1'b0};
    end
    // RULE26 readback loads the out shifter at the next frame start
    if (state_reg == ODC_IDLE && sync_fall && rd_pend_reg) begin
      out_next = {4'h0, in_reg[rd_ch_reg], 4'h0};
    end
  end

  // ---------------------------------------------------------------
  // registers, power-on and soft reset
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ODC_IDLE;
      shift_reg <= '0;
      sdo_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      sdo_reg <= sdo_next;
    end
  end

  // RULE22 RULE12 defined state at power-on and soft reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ODC_NUM_CH; i++) begin
        in_reg[i] <= ODC_CODE_RST;
        dac_reg[i] <= ODC_CODE_RST;
      end
      pwr_reg <= ODC_PWR_RST;
      mask_reg <= ODC_MASK_RST;
      ref_off_reg <= ODC_REF_OFF_RST;
      gain_reg <= ODC_GAIN_RST;
      chain_reg <= ODC_CHAIN_RST;
      rd_pend_reg <= 1'b0;
      rd_ch_reg <= 3'h0;
      out_reg <= '0;
      done_reg <= 1'b0;
    end else if (soft_rst) begin
      for (int i = 0; i < ODC_NUM_CH; i++) begin
        in_reg[i] <= ODC_CODE_RST;
        dac_reg[i] <= ODC_CODE_RST;
      end
      pwr_reg <= ODC_PWR_RST;
      mask_reg <= ODC_MASK_RST;
      ref_off_reg <= ODC_REF_OFF_RST;
      gain_reg <= ODC_GAIN_RST;
      chain_reg <= ODC_CHAIN_RST;
      rd_pend_reg <= 1'b0;
      rd_ch_reg <= 3'h0;
      out_reg <= '0;
      done_reg <= 1'b1;
    end else begin
      for (int i = 0; i < ODC_NUM_CH; i++) begin
        in_reg[i] <= in_next[i];
        dac_reg[i] <= dac_next[i];
      end
      pwr_reg <= pwr_next;
      mask_reg <= mask_next;
      ref_off_reg <= ref_off_next;
      gain_reg <= gain_next;
      chain_reg <= chain_next;
      rd_pend_reg <= rd_pend_next;
      rd_ch_reg <= rd_ch_next;
      out_reg <= out_next;
      done_reg <= done_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ODC_NUM_CH; i++) begin
      dac_codes[i*16 +: 16] = dac_reg[i];
    end
  end

  assign serial_out = sdo_reg;
  assign power_modes = pwr_reg;
  assign reference_enable = ~ref_off_reg;
  // RULE20 hardware gain pin overrides the bit
  assign gain_double = HW_GAIN_VARIANT ? gain_pin : gain_reg;
  assign chain_enable = chain_reg;
  assign frame_done = done_reg;

endmodule : odc_decoder

/* File: verif/odc_sva.sv */
// checker for the serial command decoder, sees only its ports
// assumes sync stays high two cycles between frames, sclk phases two cycles
`timescale 1ns/1ps
module odc_sva
  import odc_pkg::*;
#(
  parameter int DATA_BITS = 16,
  parameter bit HW_GAIN_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire odc_serial_t serial_in,
  input wire logic load_outputs_n,
  input wire logic gain_pin,
  input wire logic serial_out,
  input wire logic [ODC_NUM_CH*16-1:0] dac_codes,
  input wire logic [15:0] power_modes,
  input wire logic reference_enable,
  input wire logic gain_double,
  input wire logic chain_enable,
  input wire logic frame_done
);
  // ------------------------------------------------------------
  // frame execution and output causes
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic fs = serial_in.frame_n;

  property p_done_after_rise; $rose(fs) |-> ##[1:2] frame_done; endproperty
  a_done_after_rise:
    assert property (p_done_after_rise) else $error("no execute after sync rise");
  property p_done_pulse; frame_done |=> !frame_done; endproperty
  a_done_pulse:
    assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_done_idle; frame_done |-> fs && $past(fs); endproperty
  a_done_idle:
    assert property (p_done_idle) else $error("done inside a frame");
  property p_quiet_in_frame;
    (!fs) [*3] |-> $stable({dac_codes, power_modes, reference_enable, chain_enable});
  endproperty
  a_quiet_in_frame:
    assert property (p_quiet_in_frame) else $error("state moved mid frame");
  property p_setup_on_done;
    $changed({power_modes, reference_enable, chain_enable}) |-> frame_done;
  endproperty
  a_setup_on_done:
    assert property (p_setup_on_done) else $error("setup moved without frame");
  property p_gain_on_done; !HW_GAIN_VARIANT && $changed(gain_double) |-> frame_done; endproperty
  a_gain_on_done:
    assert property (p_gain_on_done) else $error("gain moved without frame");
  property p_codes_cause;
    $changed(dac_codes) |-> frame_done || !$past(load_outputs_n) ||
      !$past(load_outputs_n, 2) || !$past(load_outputs_n, 3);
  endproperty
  a_codes_cause:
    assert property (p_codes_cause) else $error("codes moved without cause");
  property p_sout_on_sclk; $changed(serial_out) |-> $past(serial_in.sclk) || frame_done; endproperty
  a_sout_on_sclk:
    assert property (p_sout_on_sclk) else $error("serial out moved off sclk");

  c_frame: cover property (frame_done);
  c_load: cover property (!load_outputs_n && fs);
  c_chain: cover property ($rose(chain_enable));
endmodule : odc_sva

bind odc_decoder odc_sva #(.DATA_BITS(DATA_BITS), .HW_GAIN_VARIANT(HW_GAIN_VARIANT)) i_odc_sva (
  .sys_clk(sys_clk), .reset(reset), .serial_in(serial_in), .load_outputs_n(load_outputs_n),
  .gain_pin(gain_pin), .serial_out(serial_out), .dac_codes(dac_codes),
  .power_modes(power_modes), .reference_enable(reference_enable),
  .gain_double(gain_double), .chain_enable(chain_enable), .frame_done(frame_done));

/* File: verif/odc_host_model.sv */
// serial master model that drives frames into the decoder
// assumes sys_clk from the bench; every pin change lands on its falling edge
`timescale 1ns/1ps
module odc_host_model
  import odc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic serial_out,
  output odc_serial_t pins
);
  // ------------------------------------------------------------
  // frame driver
  // ------------------------------------------------------------
  initial pins = '{frame_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

  task automatic wait_neg(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_neg

  task automatic send(input logic [23:0] word, input int nbits, output logic [23:0] rx);
    rx = '0;
    pins.frame_n = 1'b0;
    wait_neg(2);
    for (int i = 23; i > 23 - nbits; i--) begin
      pins.sclk = 1'b1;
      pins.sdi = word[i];
      wait_neg(2);
      rx = {rx[22:0], serial_out};
      pins.sclk = 1'b0;
      wait_neg(2);
    end
    pins.frame_n = 1'b1;
    // a released data line must not keep showing the last bit
    pins.sdi = ~pins.sdi;
    wait_neg(4);
  endtask : send
endmodule : odc_host_model

/* File: verif/odc_decoder_tb.sv */
// self-checking bench for the serial command decoder
// assumes the host model sends frames; checks run at falling clock edges
`timescale 1ns/1ps
module odc_decoder_tb import odc_pkg::*; ;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic load_outputs_n = 1'b1;
  logic gain_pin = 1'b0;
  odc_serial_t pins;
  logic serial_out, reference_enable, gain_double, chain_enable, frame_done;
  logic [ODC_NUM_CH*16-1:0] dac_codes;
  logic [15:0] power_modes, ex_pwr;
  logic [15:0] ex_in [8];
  logic [15:0] ex_dac [8];
  logic ex_ref, ex_gain, ex_chain;
  logic [23:0] rx;
  logic [23:0] odd_w [6] = '{24'h0FFFFF, 24'hC0FFFF, 24'hD1FFFF, 24'hE7FFFF, 24'hF3FFFF,
    24'h38FFFF};
  int err_count = 0;
  int comparisons = 0;

  always #20 sys_clk = ~sys_clk;

  odc_decoder i_odc_decoder (.sys_clk(sys_clk), .reset(reset), .serial_in(pins),
    .load_outputs_n(load_outputs_n), .gain_pin(gain_pin), .serial_out(serial_out),
    .dac_codes(dac_codes), .power_modes(power_modes), .reference_enable(reference_enable),
    .gain_double(gain_double), .chain_enable(chain_enable), .frame_done(frame_done));
  odc_host_model i_odc_host_model (.sys_clk(sys_clk), .serial_out(serial_out), .pins(pins));

  // ------------------------------------------------------------
  // expectation model and checks
  // ------------------------------------------------------------
  task automatic reset_exp();
    for (int i = 0; i < 8; i++) {ex_in[i], ex_dac[i]} = 32'h0;
    {ex_pwr, ex_ref, ex_gain, ex_chain} = {16'h0000, 3'b100};
  endtask : reset_exp

  task automatic model(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
    for (int i = 0; i < 8; i++) begin
      if ((c == 4'h1 || c == 4'h3) && s == i[3:0]) ex_in[i] = d;
      if ((c == 4'h2 || c == 4'h3) && s == i[3:0]) ex_dac[i] = ex_in[i];
      if (c == 4'hA || c == 4'hB) ex_in[i] = d;
      if (c == 4'hB) ex_dac[i] = d;
    end
    if (c == 4'h4) ex_pwr = d;
    if (c == 4'h7) {ex_gain, ex_ref} = {d[2], ~d[0]};
    if (c == 4'h8) ex_chain = d[0];
  endtask : model

  task automatic send(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
    i_odc_host_model.send({c, s, d}, 24, rx);
    model(c, s, d);
  endtask : send

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic check_all(input string name);
    logic [127:0] e;
    for (int i = 0; i < 8; i++) e[16*i +: 16] = ex_dac[i];
    chk(dac_codes, e);
    chk({109'h0, power_modes, reference_enable, gain_double, chain_enable},
      {109'h0, ex_pwr, ex_ref, ex_gain, ex_chain});
    $display("test %s done", name);
  endtask : check_all

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_exp();
    check_all("reset values");
    send(4'h1, 4'h3, 16'hA5C3);
    check_all("write input");
    send(4'h2, 4'h3, 16'h0000);
    check_all("update");
    for (int i = 0; i < 8; i++) send(4'h3, i[3:0], {i[3:0], 12'h5A5});
    check_all("each channel");
    foreach (odd_w[k]) send(odd_w[k][23:20], odd_w[k][19:16], odd_w[k][15:0]);
    check_all("no effect");
    send(4'h5, 4'h0, 16'h0001);
    send(4'hA, 4'h0, 16'h0F0F);
    check_all("all input");
    load_outputs_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    load_outputs_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int i = 1; i < 8; i++) ex_dac[i] = ex_in[i];
    check_all("load pin");
    send(4'h5, 4'h0, 16'h0000);
    send(4'hB, 4'h0, 16'hFFFF);
    check_all("all update");
    send(4'h4, 4'h0, 16'h5A3C);
    send(4'h7, 4'h0, 16'h0005);
    check_all("setup");
    load_outputs_n = 1'b0;
    send(4'h1, 4'h5, 16'h1234);
    load_outputs_n = 1'b1;
    for (int i = 0; i < 8; i++) ex_dac[i] = ex_in[i];
    check_all("transparent write");
    i_odc_host_model.send({2'b11, 4'h2, 16'h7E57, 2'b00}, 22, rx);
    model(4'h3, 4'h2, 16'h7E57);
    check_all("short frame");
    send(4'h1, 4'h6, 16'hC0DE);
    send(4'h9, 4'h6, 16'h0000);
    send(4'h0, 4'h0, 16'h0000);
    chk({112'h0, rx[19:4]}, {112'h0, 16'hC0DE});
    check_all("readback");
    send(4'h8, 4'h0, 16'h0001);
    check_all("chain");
    send(4'h6, 4'h0, 16'h0000);
    reset_exp();
    check_all("soft reset");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
endmodule : odc_decoder_tb
